// ### kmg_pkg.sv
//------------------------------------------------------------
//------------------------------------------------------------
package kmg_pkg;
    localparam logic [13:0] KERNEL_ENTRY_ADDR = 14'h2000;
    localparam logic [15:0] KERNEL_PAGE       = 16'h000f;
    localparam int          INPUT_CLK_MULT    = 2;
    localparam logic [1:0]  NEST_MAX          = 2'h1;
    localparam logic [3:0]  PDEPTH_MAX        = 4'hf;
    // register offsets
    localparam logic [3:0]  ADDR_STATUS  = 4'h0;
    localparam logic [3:0]  ADDR_MASK    = 4'h1;
    localparam logic [3:0]  ADDR_STATE   = 4'h2;
    localparam logic [3:0]  ADDR_CONFIG  = 4'h3;
    localparam logic [3:0]  ADDR_BYPASS  = 4'h4;
    // status bit positions
    localparam int ST_ENTER = 0;
    localparam int ST_EXIT  = 1;
    localparam int ST_VIOL  = 2;
    localparam logic [2:0] MASK_RST = 3'h0;
    typedef enum logic [1:0] {
        KMG_USER   = 2'b00,
        KMG_KERNEL = 2'b01,
        KMG_UIRQ   = 2'b11,
        KMG_NESTED = 2'b10
    } kmg_mode_e;
    typedef enum logic [1:0] {
        KMG_PERS_HOSTPORT = 2'h0,
        KMG_PERS_PCI      = 2'h1,
        KMG_PERS_BAD      = 2'h2
    } kmg_pers_e;
    typedef enum logic [1:0] {
        KMG_BOOT_BYTEMEM = 2'h0,
        KMG_BOOT_HOSTBUS = 2'h1,
        KMG_BOOT_PROGMEM = 2'h2,
        KMG_BOOT_BAD     = 2'h3
    } kmg_boot_e;
endpackage

// ### kmg_guard.sv
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module kmg_guard
    import kmg_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_srst,
    // processor flow events
    input  wire logic        i_jump_call,
    input  wire logic [13:0] i_target_addr,
    input  wire logic [15:0] i_program_overlay_page,
    input  wire logic        i_op_done,
    input  wire logic        i_irq_take,
    input  wire logic        i_irq_protected,
    input  wire logic [13:0] i_irq_ret_addr,
    input  wire logic        i_return_from_interrupt_instr,
    input  wire logic [13:0] i_ret_addr,
    input  wire logic [15:0] i_ret_page,
    // straps
    input  wire logic        i_bus_mode_strap,
    input  wire logic        i_bus_sel_strap,
    input  wire logic        i_boot_source_strap,
    input  wire logic        i_memory_map_strap,
    // register port
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    // outputs
    output logic             o_kernel_mode,
    output logic             o_violation_rst,
    output logic [1:0]       o_personality,
    output logic [1:0]       o_boot_source,
    output logic             o_hostbus_boot_pci,
    output logic             o_bypass_en,
    output logic             o_irq
);
    //------------------------------------------------------------
    // strap synchronisers and release capture
    //------------------------------------------------------------
    logic [3:0] strap_s1_r, strap_s2_r, strap_s3_r;
    logic       in_rst_r;
    logic [1:0] pers_r, boot_r;
    always_ff @(posedge i_clk_sys) begin
        strap_s1_r <= {i_bus_mode_strap, i_bus_sel_strap,
                       i_boot_source_strap, i_memory_map_strap};
        strap_s2_r <= strap_s1_r;
        strap_s3_r <= strap_s2_r;
    end
    always_ff @(posedge i_clk_sys) begin
        in_rst_r <= i_srst;
        // capture on first cycle out of reset if the synchronised straps are steady, then hold
        if (in_rst_r && !i_srst && strap_s2_r == strap_s3_r) begin
            unique case (strap_s2_r[3:2])
                2'b00:   pers_r <= KMG_PERS_HOSTPORT;
                2'b10:   pers_r <= KMG_PERS_PCI;
                default: pers_r <= KMG_PERS_BAD;
            endcase
            unique case (strap_s2_r[1:0])
                2'b00:   boot_r <= KMG_BOOT_BYTEMEM;
                2'b10:   boot_r <= KMG_BOOT_HOSTBUS;
                2'b01:   boot_r <= KMG_BOOT_PROGMEM;
                default: boot_r <= KMG_BOOT_BAD;
            endcase
        end else if (i_srst) begin
            pers_r <= KMG_PERS_HOSTPORT;
            boot_r <= KMG_BOOT_BYTEMEM;
        end
        // otherwise straps ignored
    end
    always_ff @(posedge i_clk_sys) begin
        o_personality      <= pers_r;
        o_boot_source      <= boot_r;
        o_hostbus_boot_pci <= (boot_r == KMG_BOOT_HOSTBUS) && (pers_r == KMG_PERS_PCI);
    end

    //------------------------------------------------------------
    // kernel mode tracker
    //------------------------------------------------------------
    kmg_mode_e   mode_r;
    logic [13:0] sav_addr_r;
    logic [15:0] sav_page_r;
    logic [3:0]  pdepth_r;
    logic        viol_r;
    logic        entry;
    logic        ret_ok;
    logic        in_k;
    assign entry  = i_jump_call && i_target_addr == KERNEL_ENTRY_ADDR
                    && i_program_overlay_page == KERNEL_PAGE;
    assign ret_ok = i_ret_addr == sav_addr_r && i_ret_page == sav_page_r;
    assign in_k   = mode_r == KMG_KERNEL || mode_r == KMG_NESTED;

    always_ff @(posedge i_clk_sys) begin
        viol_r <= 1'b0;
        if (i_srst || viol_r) begin
            mode_r   <= KMG_USER;
            pdepth_r <= 4'h0;
        end else if (pdepth_r != 4'h0) begin
            // protected handler runs in kernel mode
            if (i_irq_take && i_irq_protected && pdepth_r != PDEPTH_MAX)
                pdepth_r <= pdepth_r + 4'h1;
            else if (i_return_from_interrupt_instr)
                pdepth_r <= pdepth_r - 4'h1;
        end else begin
            unique case (mode_r)
                KMG_USER: begin
                    if (entry)
                        mode_r <= KMG_KERNEL;
                end
                KMG_KERNEL: begin
                    if (i_irq_take && i_irq_protected) begin
                        pdepth_r <= 4'h1;
                    end else if (i_irq_take) begin
                        mode_r     <= KMG_UIRQ;
                        sav_addr_r <= i_irq_ret_addr;
                        sav_page_r <= i_program_overlay_page;
                    end else if (i_op_done) begin
                        mode_r <= KMG_USER;
                    end
                end
                KMG_UIRQ: begin
                    if (entry) begin
                        mode_r <= KMG_NESTED;
                    end else if (i_return_from_interrupt_instr) begin
                        if (ret_ok)
                            mode_r <= KMG_KERNEL;
                        else
                            viol_r <= 1'b1;
                    end
                end
                KMG_NESTED: begin
                    if (i_irq_take && i_irq_protected) begin
                        pdepth_r <= 4'h1;
                    end else if (i_irq_take || entry) begin
                        viol_r <= 1'b1;
                    end else if (i_op_done) begin
                        mode_r <= KMG_UIRQ;
                    end
                end
            endcase
        end
    end
    always_ff @(posedge i_clk_sys) begin
        o_kernel_mode   <= !i_srst && !viol_r && (in_k || pdepth_r != 4'h0);
        o_violation_rst <= !i_srst && viol_r;
    end

    //------------------------------------------------------------
    // registers and interrupt
    //------------------------------------------------------------
    logic [2:0] status_r, mask_r, ev;
    logic       bypass_r;
    logic       kprev_r;
    always_ff @(posedge i_clk_sys) begin
        kprev_r <= o_kernel_mode;
    end
    assign ev = {viol_r, kprev_r && !o_kernel_mode, !kprev_r && o_kernel_mode};
    always_ff @(posedge i_clk_sys) begin
        if (i_srst)
            status_r <= 3'h0;
        else if (i_rd && i_addr == ADDR_STATUS)
            status_r <= ev; // set wins over clear
        else
            status_r <= status_r | ev;
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            mask_r   <= MASK_RST;
            bypass_r <= 1'b0;
        end else if (i_wr) begin
            if (i_addr == ADDR_MASK)
                mask_r <= i_wdata[2:0];
            if (i_addr == ADDR_BYPASS)
                bypass_r <= i_wdata[0];
        end
    end
    always_ff @(posedge i_clk_sys) begin
        o_bypass_en <= !i_srst && bypass_r && !o_kernel_mode;
        o_irq       <= !i_srst && |(status_r & mask_r);
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || !i_rd) begin
            o_rdata <= 16'h0000;
        end else begin
            unique case (i_addr)
                ADDR_STATUS: o_rdata <= {13'h0000, status_r};
                ADDR_MASK:   o_rdata <= {13'h0000, mask_r};
                ADDR_STATE:  o_rdata <= {10'h000, pdepth_r, mode_r};
                ADDR_CONFIG: o_rdata <= {12'h000, boot_r, pers_r};
                ADDR_BYPASS: o_rdata <= {15'h0000, bypass_r};
                default:     o_rdata <= 16'h0000;
            endcase
        end
    end

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    property p_entry;
        @(posedge i_clk_sys) disable iff (i_srst)
        mode_r == KMG_USER && pdepth_r == 4'h0 && entry && !viol_r
        |=> mode_r == KMG_KERNEL;
    endproperty
    a_entry: assert property (p_entry) else $error("kernel entry missed");
    property p_noentry;
        @(posedge i_clk_sys) disable iff (i_srst)
        mode_r == KMG_USER && !entry |=> mode_r == KMG_USER;
    endproperty
    a_noentry: assert property (p_noentry) else $error("kernel entered wrongly");
    property p_exit;
        @(posedge i_clk_sys) disable iff (i_srst)
        mode_r == KMG_KERNEL && pdepth_r == 4'h0 && !i_irq_take && i_op_done && !viol_r
        |=> mode_r == KMG_USER ##1 !o_kernel_mode;
    endproperty
    a_exit: assert property (p_exit) else $error("kernel did not exit");
    property p_badret;
        @(posedge i_clk_sys) disable iff (i_srst)
        mode_r == KMG_UIRQ && pdepth_r == 4'h0 && !entry && !viol_r
        && i_return_from_interrupt_instr && !ret_ok |=> viol_r ##1 o_violation_rst;
    endproperty
    a_badret: assert property (p_badret) else $error("bad return not caught");
    property p_nestirq;
        @(posedge i_clk_sys) disable iff (i_srst)
        mode_r == KMG_NESTED && pdepth_r == 4'h0 && !viol_r
        && i_irq_take && !i_irq_protected |=> viol_r;
    endproperty
    a_nestirq: assert property (p_nestirq) else $error("nested irq not caught");
    property p_viol_clear;
        @(posedge i_clk_sys) disable iff (i_srst)
        viol_r |=> mode_r == KMG_USER && pdepth_r == 4'h0 ##1 !o_kernel_mode;
    endproperty
    a_viol_clear: assert property (p_viol_clear) else $error("violation kept state");
    property p_prot;
        @(posedge i_clk_sys) disable iff (i_srst)
        pdepth_r != 4'h0 && !viol_r |=> o_kernel_mode;
    endproperty
    a_prot: assert property (p_prot) else $error("left kernel in handler");
    property p_strap_hold;
        @(posedge i_clk_sys) disable iff (i_srst)
        !in_rst_r |=> $stable(pers_r) && $stable(boot_r);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed");
    property p_pers_cap;
        @(posedge i_clk_sys) disable iff (i_srst)
        in_rst_r && strap_s2_r == strap_s3_r && strap_s2_r[3:2] == 2'b10
        |=> pers_r == KMG_PERS_PCI;
    endproperty
    a_pers_cap: assert property (p_pers_cap) else $error("pci strap not captured");
    property p_boot_cap;
        @(posedge i_clk_sys) disable iff (i_srst)
        in_rst_r && strap_s2_r == strap_s3_r && strap_s2_r[1:0] == 2'b01
        |=> boot_r == KMG_BOOT_PROGMEM;
    endproperty
    a_boot_cap: assert property (p_boot_cap) else $error("boot strap not captured");
    property p_hostpci;
        @(posedge i_clk_sys) disable iff (i_srst)
        o_hostbus_boot_pci |-> o_boot_source == KMG_BOOT_HOSTBUS
        && o_personality == KMG_PERS_PCI;
    endproperty
    a_hostpci: assert property (p_hostpci) else $error("host boot flag wrong");

    // user interrupt taken from plain kernel
    sequence s_uirq_take;
        mode_r == KMG_KERNEL && pdepth_r == 4'h0 && i_irq_take && !i_irq_protected && !viol_r;
    endsequence
    sequence s_uirq_saved;
        mode_r == KMG_UIRQ && sav_addr_r == $past(i_irq_ret_addr)
        && sav_page_r == $past(i_program_overlay_page) ##1 !o_kernel_mode;
    endsequence
    property p_uirq;
        @(posedge i_clk_sys) disable iff (i_srst)
        s_uirq_take |=> s_uirq_saved;
    endproperty
    a_uirq: assert property (p_uirq) else $error("user irq not tracked");
    property p_reenter;
        @(posedge i_clk_sys) disable iff (i_srst)
        mode_r == KMG_UIRQ && pdepth_r == 4'h0 && entry && !viol_r
        |=> mode_r == KMG_NESTED;
    endproperty
    a_reenter: assert property (p_reenter) else $error("kernel reentry missed");
    property p_goodret;
        @(posedge i_clk_sys) disable iff (i_srst)
        mode_r == KMG_UIRQ && pdepth_r == 4'h0 && !entry && !viol_r
        && i_return_from_interrupt_instr && ret_ok |=> mode_r == KMG_KERNEL && !viol_r;
    endproperty
    a_goodret: assert property (p_goodret) else $error("good return refused");
    property p_deep;
        @(posedge i_clk_sys) disable iff (i_srst)
        mode_r == KMG_NESTED && pdepth_r == 4'h0 && entry && !viol_r
        && !(i_irq_take && i_irq_protected) |=> viol_r;
    endproperty
    a_deep: assert property (p_deep) else $error("deep nesting not caught");
    property p_nest_done;
        @(posedge i_clk_sys) disable iff (i_srst)
        mode_r == KMG_NESTED && pdepth_r == 4'h0 && !i_irq_take && !entry
        && i_op_done && !viol_r |=> mode_r == KMG_UIRQ;
    endproperty
    a_nest_done: assert property (p_nest_done) else $error("nested exit wrong");

    // protected handlers
    property p_prot_enter;
        @(posedge i_clk_sys) disable iff (i_srst)
        in_k && pdepth_r == 4'h0 && i_irq_take && i_irq_protected && !viol_r
        |=> pdepth_r == 4'h1;
    endproperty
    a_prot_enter: assert property (p_prot_enter) else $error("protected irq missed");
    property p_prot_nest;
        @(posedge i_clk_sys) disable iff (i_srst)
        pdepth_r != 4'h0 && pdepth_r != PDEPTH_MAX && i_irq_take && i_irq_protected
        && !viol_r |=> pdepth_r == $past(pdepth_r) + 4'h1;
    endproperty
    a_prot_nest: assert property (p_prot_nest) else $error("protected nest missed");
    property p_prot_ret;
        @(posedge i_clk_sys) disable iff (i_srst)
        pdepth_r != 4'h0 && !(i_irq_take && i_irq_protected)
        && i_return_from_interrupt_instr && !viol_r |=> pdepth_r == $past(pdepth_r) - 4'h1;
    endproperty
    a_prot_ret: assert property (p_prot_ret) else $error("protected return missed");
    property p_prot_mode;
        @(posedge i_clk_sys) disable iff (i_srst)
        pdepth_r != 4'h0 && !viol_r |=> mode_r == $past(mode_r);
    endproperty
    a_prot_mode: assert property (p_prot_mode) else $error("mode moved in handler");

    // violation pulse and mode output
    sequence s_viol_out;
        !viol_r && o_violation_rst ##1 !o_violation_rst;
    endsequence
    property p_viol_pulse;
        @(posedge i_clk_sys) disable iff (i_srst)
        viol_r |=> s_viol_out;
    endproperty
    a_viol_pulse: assert property (p_viol_pulse) else $error("violation pulse wrong");
    property p_viol_src;
        @(posedge i_clk_sys) disable iff (i_srst)
        o_violation_rst |-> $past(viol_r);
    endproperty
    a_viol_src: assert property (p_viol_src) else $error("stray violation pulse");
    property p_kmode_track;
        @(posedge i_clk_sys) disable iff (i_srst)
        !viol_r |=> o_kernel_mode == $past(in_k || pdepth_r != 4'h0);
    endproperty
    a_kmode_track: assert property (p_kmode_track) else $error("kernel flag wrong");
    property p_bypass_k;
        @(posedge i_clk_sys) disable iff (i_srst)
        o_kernel_mode |=> !o_bypass_en;
    endproperty
    a_bypass_k: assert property (p_bypass_k) else $error("bypass open in kernel");

    // register port and interrupt
    property p_irq;
        @(posedge i_clk_sys) disable iff (i_srst)
        (status_r & mask_r) != 3'h0 |=> o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");
    property p_rd_idle;
        @(posedge i_clk_sys) disable iff (i_srst)
        !i_rd |=> o_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
endmodule

// ### kmg_strap_model.sv
`timescale 1ns/10ps
module kmg_strap_model (
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_srst,
    // chosen strap levels {bus mode, bus sel, boot source, memory map}
    input  wire logic [3:0] i_choice,
    // strap pins
    output logic            o_bus_mode_strap,
    output logic            o_bus_sel_strap,
    output logic            o_boot_source_strap,
    output logic            o_memory_map_strap
);
    logic [3:0] pins_r;
    logic [1:0] hold_r;

    // straps steady through reset and three cycles after it, then inverted every cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            pins_r <= i_choice;
            hold_r <= 2'h0;
        end else if (hold_r != 2'h3) begin
            hold_r <= hold_r + 2'h1;
        end else begin
            pins_r <= ~pins_r;
        end
    end

    assign {o_bus_mode_strap, o_bus_sel_strap, o_boot_source_strap, o_memory_map_strap} = pins_r;
endmodule

// ### tb_kernel_mode_guard_boot_config.sv
`timescale 1ns/10ps
module tb_kernel_mode_guard_boot_config;
    import kmg_pkg::*;
    localparam logic [4:0]  J = 5'h01, D = 5'h02, I = 5'h04, P = 5'h0c, R = 5'h10;
    localparam logic [13:0] KE = KERNEL_ENTRY_ADDR;
    localparam logic [15:0] KP = KERNEL_PAGE;
    logic        clk, srst, jmp, done, irq, prot, ret, wr, rd;
    logic        bm, bs, bo, mm, kern, viol, oirq, byp, hpci;
    logic [13:0] addr14;
    logic [15:0] page, wdata, rdata;
    logic [3:0]  choice, raddr;
    logic [1:0]  pers, boot;
    logic [3:0]  combos [5] = '{4'ha, 4'h2, 4'h1, 4'h4, 4'h3};
    int          bad_count, tests_run, viol_cnt, seed;

    kmg_strap_model kmg_strap_model_inst (.i_clk_sys(clk), .i_srst(srst), .i_choice(choice),
        .o_bus_mode_strap(bm), .o_bus_sel_strap(bs), .o_boot_source_strap(bo),
        .o_memory_map_strap(mm));
    kmg_guard kmg_guard_inst (.i_clk_sys(clk), .i_srst(srst), .i_jump_call(jmp),
        .i_target_addr(addr14), .i_program_overlay_page(page), .i_op_done(done),
        .i_irq_take(irq), .i_irq_protected(prot), .i_irq_ret_addr(addr14),
        .i_return_from_interrupt_instr(ret), .i_ret_addr(addr14), .i_ret_page(page),
        .i_bus_mode_strap(bm), .i_bus_sel_strap(bs), .i_boot_source_strap(bo),
        .i_memory_map_strap(mm), .i_addr(raddr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_kernel_mode(kern), .o_violation_rst(viol), .o_personality(pers),
        .o_boot_source(boot), .o_hostbus_boot_pci(hpci), .o_bypass_en(byp), .o_irq(oirq));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) if (viol === 1'b1) viol_cnt++;

    function automatic logic [1:0] exp_pers(input logic [3:0] c);
        return c[2] ? KMG_PERS_BAD : (c[3] ? KMG_PERS_PCI : KMG_PERS_HOSTPORT);
    endfunction
    function automatic logic [1:0] exp_boot(input logic [3:0] c);
        if (c[1] && c[0]) return KMG_BOOT_BAD;
        return c[1] ? KMG_BOOT_HOSTBUS : (c[0] ? KMG_BOOT_PROGMEM : KMG_BOOT_BYTEMEM);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic step(input logic [4:0] k, input logic [13:0] a, input logic [15:0] p,
                        input logic ek, input int ev);
        int v0;
        v0 = viol_cnt;
        @(posedge clk);
        {ret, prot, irq, done, jmp} <= k;
        addr14 <= a;
        page <= p;
        @(posedge clk);
        {ret, prot, irq, done, jmp} <= 5'h0;
        idle(4);
        chk({15'h0, kern}, {15'h0, ek});
        chk(16'(viol_cnt - v0), 16'(ev));
    endtask
    task automatic wrt(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        raddr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        raddr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic do_reset(input logic [3:0] c);
        @(posedge clk);
        srst <= 1'b1;
        choice <= c;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        idle(8);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge clk);
        bad_count++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [13:0] a;
        logic [15:0] p;
        {srst, jmp, done, irq, prot, ret, wr, rd} = 8'h80;
        {addr14, page, wdata, raddr, choice} = '0;
        {bad_count, tests_run, viol_cnt, seed} = {32'd0, 32'd0, 32'd0, 32'd76};
        foreach (combos[n]) begin
            do_reset(combos[n]);
            chk({14'h0, pers}, {14'h0, exp_pers(combos[n])});
            chk({14'h0, boot}, {14'h0, exp_boot(combos[n])});
            chk({15'h0, hpci}, 16'(combos[n] == 4'ha));
            rdchk(ADDR_CONFIG, {12'h0, exp_boot(combos[n]), exp_pers(combos[n])});
        end
        $display("test straps done");
        for (int i = 0; i < 16; i++) begin
            a = i[0] ? KE : 14'($random(seed));
            p = i[0] ? 16'($random(seed)) : KP;
            if (a == KE && p == KP) p = p ^ 16'h0100;
            step(J, a, p, 1'b0, 0);
        end
        step(J, KE, KP, 1'b1, 0);
        step(D, 14'h0, KP, 1'b0, 0);
        step(J, KE, KP, 1'b1, 0);
        step(I, 14'h0123, KP, 1'b0, 0);
        step(J, KE, KP, 1'b1, 0);
        step(D, 14'h0, KP, 1'b0, 0);
        step(R, 14'h0123, KP, 1'b1, 0);
        step(D, 14'h0, KP, 1'b0, 0);
        step(J, KE, KP, 1'b1, 0);
        step(I, 14'h0200, KP, 1'b0, 0);
        step(R, 14'h0201, KP, 1'b0, 1);
        step(J, KE, KP, 1'b1, 0);
        step(I, 14'h0200, KP, 1'b0, 0);
        step(R, 14'h0200, 16'h000e, 1'b0, 1);
        step(J, KE, KP, 1'b1, 0);
        step(I, 14'h0300, KP, 1'b0, 0);
        step(J, KE, KP, 1'b1, 0);
        step(I, 14'h0301, KP, 1'b0, 1);
        step(J, KE, KP, 1'b1, 0);
        step(I, 14'h0300, KP, 1'b0, 0);
        step(J, KE, KP, 1'b1, 0);
        step(J, KE, KP, 1'b0, 1);
        $display("test kernel flow done");
        step(J, KE, KP, 1'b1, 0);
        for (int i = 0; i < 3; i++) step(P, 14'h0400, KP, 1'b1, 0);
        for (int i = 0; i < 3; i++) step(R, 14'h0400, KP, 1'b1, 0);
        step(D, 14'h0, KP, 1'b0, 0);
        $display("test protected nesting done");
        do_reset(4'ha);
        rdchk(ADDR_MASK, {13'h0, MASK_RST});
        rdchk(ADDR_STATUS, 16'h0000);
        wrt(ADDR_MASK, 16'h0007);
        step(J, KE, KP, 1'b1, 0);
        chk({15'h0, oirq}, 16'h0001);
        rdchk(ADDR_STATUS, 16'h0001);
        rdchk(ADDR_STATE, {14'h0, KMG_KERNEL});
        idle(2);
        chk({15'h0, oirq}, 16'h0000);
        wrt(ADDR_BYPASS, 16'h0001);
        idle(3);
        chk({15'h0, byp}, 16'h0000);
        step(D, 14'h0, KP, 1'b0, 0);
        chk({15'h0, byp}, 16'h0001);
        chk({15'h0, oirq}, 16'h0001);
        wrt(ADDR_MASK, 16'h0000);
        idle(3);
        chk({15'h0, oirq}, 16'h0000);
        rdchk(ADDR_STATUS, 16'h0002);
        rdchk(4'hf, 16'h0000);
        rdchk(ADDR_BYPASS, 16'h0001);
        $display("test registers done");
        give_verdict();
    end
endmodule
